// ---- rtl/isf_defs.svh ----
// register offsets, field positions and reset values of the slave flag block
// assumes: byte addresses on an 8-bit apb address, one word per register
`ifndef ISF_DEFS_SVH
`define ISF_DEFS_SVH

`define ISF_OFF_STATUS  8'h00
`define ISF_OFF_CTRL    8'h04
`define ISF_OFF_DATA    8'h08
`define ISF_OFF_SAR1    8'h0c
`define ISF_OFF_SAR2    8'h10
`define ISF_OFF_BUF     8'h14
`define ISF_OFF_IST     8'h18
`define ISF_OFF_IMASK   8'h1c

// bus_status_reg fields
`define ISF_ST_ERR      7
`define ISF_ST_NORM     6
`define ISF_ST_FDONE    5
`define ISF_ST_SECOND   4
`define ISF_ST_ARB      3
`define ISF_ST_OWN      2
`define ISF_ST_BCAST    1
`define ISF_ST_ACK      0
// bit 0 (ack_bit_flag) is not cleared by a status write
`define ISF_ST_CLR_MASK 8'hfe

// bus_control_reg fields
`define ISF_CT_IRQ      0
`define ISF_CT_BUSY     1
`define ISF_CT_MST      2
`define ISF_CT_TRS      3

// buffer flag register fields
`define ISF_BF_RXF      0
`define ISF_BF_TXE      1

// interrupt status / mask fields
`define ISF_IE_RX       0
`define ISF_IE_TX       1
`define ISF_IE_STOP     2
`define ISF_IE_ADDR     3

`define ISF_RST_STATUS  8'h00
`define ISF_RST_SAR     7'h00
`define ISF_RST_IMASK   4'h0

`endif

// ---- rtl/isf_pkg.sv ----
// types shared by the slave flag block
// assumes: nothing beyond the defs header
package isf_pkg;

    typedef enum logic [2:0] {
        isf_idle,
        isf_addr,
        isf_aack,
        isf_rx,
        isf_tx,
        isf_tack,
        isf_ignore
    } isf_state_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } isf_sync_t;

    typedef struct packed {
        logic scl_d;
        logic sda_d;
    } isf_det_t;

    typedef struct packed {
        isf_state_t  st;
        logic [3:0]  bitcnt;
        logic [7:0]  shift;
        logic [7:0]  rx_hold;
        logic [7:0]  tx_hold;
        logic [7:0]  status;
        logic [7:0]  seen;
        logic        irq_flag;
        logic        busy;
        logic        master_select;
        logic        transmit_select;
        logic        rx_full;
        logic        tx_empty;
        logic        rx_pend;
        logic        tx_pend;
        logic [6:0]  sar1;
        logic [6:0]  sar2;
        logic [3:0]  ist;
        logic [3:0]  imask;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        sda_out;
        logic        sda_oe_n;
    } isf_main_t;

endpackage : isf_pkg

// ---- rtl/isf_sync.sv ----
// two-stage synchroniser for the scl and sda pins
// assumes: pins are asynchronous to clock; bus idles high
module isf_sync (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    output logic      scl_s,
    output logic      sda_s
);
    isf_pkg::isf_sync_t r_reg;
    isf_pkg::isf_sync_t r_next;

    always_comb begin
        r_next    = r_reg;
        r_next.s1 = {scl_pin, sda_pin};
        r_next.s2 = r_reg.s1;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r_reg <= '1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign scl_s = r_reg.s2[1];
    assign sda_s = r_reg.s2[0];
endmodule : isf_sync

// ---- rtl/isf_cond_det.sv ----
// start, stop and scl edge detection on synchronised bus lines
// assumes: inputs already synchronised to clock
module isf_cond_det (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic scl_s,
    input  wire logic sda_s,
    output logic      start_p,
    output logic      stop_p,
    output logic      rise_p,
    output logic      fall_p
);
    isf_pkg::isf_det_t r_reg;
    isf_pkg::isf_det_t r_next;

    always_comb begin
        r_next       = r_reg;
        r_next.scl_d = scl_s;
        r_next.sda_d = sda_s;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r_reg <= '1;
        end else begin
            r_reg <= r_next;
        end
    end

    // sda moving while scl stays high is a bus condition, never data
    assign start_p = scl_s & r_reg.scl_d & r_reg.sda_d & ~sda_s;
    assign stop_p  = scl_s & r_reg.scl_d & ~r_reg.sda_d & sda_s;
    assign rise_p  = scl_s & ~r_reg.scl_d;
    assign fall_p  = ~scl_s & r_reg.scl_d;
endmodule : isf_cond_det

// ---- rtl/isf_slave.sv ----
// two-wire bus slave with status flags, data buffers and an apb register file
// assumes: apb master on clock; remote bus master drives scl, sda open drain
`include "isf_defs.svh"

// Behaviour
// - a start condition clears the second address match flag
// - first address match sets own match and rx full, master select stays 0
// - on address match transmit select takes the read/write bit
// - second address match sets frame done, second match and rx full only
// - buffer events set frame done only while second match flag is 1
// - cpu data write clears tx empty, arbitration lost and own match
// - tx end with tx empty kept; later write reloads shifter, sets empty
// - reception end with rx full 0 sets rx full
// - data read clears four flags; pending byte then moves and sets rx full
// - stop during a frame sets the error end flag, bit 7
// - stop after a completed frame sets the normal end flag, bit 6
// - error end flag clears on a 0 write after reading it as 1
// - clearing the bus interrupt flag also clears the error end flag
// - end flags only updated in slave mode
// - status flags accept only 0 writes to clear; 1 writes do nothing
module isf_slave (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n
);
    isf_pkg::isf_main_t r_reg;
    isf_pkg::isf_main_t r_next;

    logic        scl_s;
    logic        sda_s;
    logic        start_p;
    logic        stop_p;
    logic        rise_p;
    logic        fall_p;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        ctrl_wr;
    logic        data_wr;
    logic        data_rd;
    logic        m1_hit;
    logic        m2_hit;
    logic        gc_hit;
    logic        hit_rw;
    logic        rx_done;
    logic        tx_load;
    logic        in_frame;
    logic        rerr;
    logic [7:0]  byte_in;
    logic [3:0]  ev;
    logic [3:0]  iclr;
    logic [31:0] rdat;

    isf_sync u_sync (
        .clock   (clock),
        .rst     (rst),
        .scl_pin (scl_in),
        .sda_pin (sda_in),
        .scl_s   (scl_s),
        .sda_s   (sda_s)
    );

    isf_cond_det u_det (
        .clock   (clock),
        .rst     (rst),
        .scl_s   (scl_s),
        .sda_s   (sda_s),
        .start_p (start_p),
        .stop_p  (stop_p),
        .rise_p  (rise_p),
        .fall_p  (fall_p)
    );

    always_comb begin
        r_next   = r_reg;
        ev       = 4'h0;
        iclr     = 4'h0;
        m1_hit   = 1'b0;
        m2_hit   = 1'b0;
        gc_hit   = 1'b0;
        hit_rw   = 1'b0;
        rx_done  = 1'b0;
        tx_load  = 1'b0;
        rerr     = 1'b0;
        rdat     = 32'h0;
        byte_in  = {r_reg.shift[6:0], sda_s};
        acc      = psel & penable & r_reg.pready;
        wr       = acc & pwrite;
        rd       = acc & ~pwrite;
        ctrl_wr  = wr & (paddr == `ISF_OFF_CTRL);
        data_wr  = wr & (paddr == `ISF_OFF_DATA);
        data_rd  = rd & (paddr == `ISF_OFF_DATA);
        // the stop's own scl rise is counted, so one bit means no frame yet
        in_frame = (r_reg.st == isf_pkg::isf_addr ||
                    r_reg.st == isf_pkg::isf_rx ||
                    r_reg.st == isf_pkg::isf_tx) && r_reg.bitcnt > 4'h1;

        // read data is captured in the setup cycle, answered one cycle later
        case (paddr)
            `ISF_OFF_STATUS: rdat[7:0] = r_reg.status;
            `ISF_OFF_CTRL: begin
                rdat[`ISF_CT_IRQ]  = r_reg.irq_flag;
                rdat[`ISF_CT_BUSY] = r_reg.busy;
                rdat[`ISF_CT_MST]  = r_reg.master_select;
                rdat[`ISF_CT_TRS]  = r_reg.transmit_select;
            end
            `ISF_OFF_DATA:  rdat[7:0] = r_reg.rx_hold;
            `ISF_OFF_SAR1:  rdat[7:1] = r_reg.sar1;
            `ISF_OFF_SAR2:  rdat[7:1] = r_reg.sar2;
            `ISF_OFF_BUF: begin
                rdat[`ISF_BF_RXF] = r_reg.rx_full;
                rdat[`ISF_BF_TXE] = r_reg.tx_empty;
            end
            `ISF_OFF_IST:   rdat[3:0] = r_reg.ist;
            `ISF_OFF_IMASK: rdat[3:0] = r_reg.imask;
            default:        rerr = 1'b1;
        endcase
        r_next.pready  = psel & ~penable;
        r_next.prdata  = r_next.pready ? rdat : 32'h0;
        r_next.pslverr = r_next.pready & rerr;

        // software effects first so that a bus event in the same cycle wins
        if (wr) begin
            case (paddr)
                `ISF_OFF_STATUS: r_next.status = r_reg.status &
                    ~(~pwdata[7:0] & r_reg.seen & `ISF_ST_CLR_MASK);
                `ISF_OFF_CTRL: begin
                    r_next.master_select = pwdata[`ISF_CT_MST];
                    if (!pwdata[`ISF_CT_IRQ]) begin
                        r_next.irq_flag              = 1'b0;
                        r_next.status[`ISF_ST_ERR]   = 1'b0;
                        r_next.status[`ISF_ST_FDONE] = 1'b0;
                    end
                end
                `ISF_OFF_DATA: begin
                    r_next.tx_hold             = pwdata[7:0];
                    r_next.tx_empty            = 1'b0;
                    r_next.status[`ISF_ST_ARB] = 1'b0;
                    r_next.status[`ISF_ST_OWN] = 1'b0;
                    if (r_reg.tx_pend) begin
                        // holding register goes straight on to the shifter
                        r_next.shift    = pwdata[7:0];
                        r_next.tx_empty = 1'b1;
                        r_next.tx_pend  = 1'b0;
                        r_next.status[`ISF_ST_FDONE] =
                            r_reg.status[`ISF_ST_FDONE] |
                            r_reg.status[`ISF_ST_SECOND];
                        r_next.irq_flag = 1'b1;
                        ev[`ISF_IE_TX]  = 1'b1;
                    end
                end
                `ISF_OFF_SAR1:  r_next.sar1  = pwdata[7:1];
                `ISF_OFF_SAR2:  r_next.sar2  = pwdata[7:1];
                `ISF_OFF_IST:   iclr         = pwdata[3:0];
                `ISF_OFF_IMASK: r_next.imask = pwdata[3:0];
                default: ;
            endcase
        end
        if (rd && paddr == `ISF_OFF_STATUS) begin
            r_next.seen = r_reg.prdata[7:0];
        end
        if (data_rd) begin
            r_next.rx_full               = 1'b0;
            r_next.status[`ISF_ST_ARB]   = 1'b0;
            r_next.status[`ISF_ST_OWN]   = 1'b0;
            r_next.status[`ISF_ST_BCAST] = 1'b0;
            if (r_reg.rx_pend) begin
                r_next.rx_hold = r_reg.shift;
                r_next.rx_full = 1'b1;
                r_next.rx_pend = 1'b0;
                r_next.status[`ISF_ST_FDONE] =
                    r_reg.status[`ISF_ST_FDONE] |
                    r_reg.status[`ISF_ST_SECOND];
                r_next.irq_flag = 1'b1;
                ev[`ISF_IE_RX]  = 1'b1;
            end
        end

        // bus side
        if (start_p) begin
            r_next.st                     = isf_pkg::isf_addr;
            r_next.bitcnt                 = 4'h0;
            r_next.busy                   = 1'b1;
            r_next.status[`ISF_ST_SECOND] = 1'b0;
            r_next.tx_empty               = 1'b1;
            r_next.tx_pend                = 1'b0;
            r_next.rx_pend                = 1'b0;
            r_next.transmit_select                    = 1'b0;
            r_next.sda_oe_n               = 1'b1;
            ev[`ISF_IE_TX]                = 1'b1;
        end else if (stop_p) begin
            r_next.st       = isf_pkg::isf_idle;
            r_next.busy     = 1'b0;
            r_next.tx_empty = 1'b0;
            r_next.tx_pend  = 1'b0;
            r_next.sda_oe_n = 1'b1;
            if (!r_reg.master_select) begin
                // the two end flags are kept mutually exclusive
                r_next.status[`ISF_ST_ERR]  = in_frame;
                r_next.status[`ISF_ST_NORM] = ~in_frame;
            end
            r_next.irq_flag  = 1'b1;
            ev[`ISF_IE_STOP] = 1'b1;
        end else begin
            unique case (r_reg.st)
                isf_pkg::isf_addr, isf_pkg::isf_rx: begin
                    if (rise_p) begin
                        r_next.shift  = byte_in;
                        r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    end
                    if (rise_p && r_reg.bitcnt == 4'h7) begin
                        r_next.st     = isf_pkg::isf_aack;
                        r_next.bitcnt = 4'h0;
                        if (r_reg.st == isf_pkg::isf_rx) begin
                            rx_done = 1'b1;
                            if (!r_next.rx_full) begin
                                r_next.rx_hold = byte_in;
                                r_next.rx_full = 1'b1;
                                r_next.status[`ISF_ST_FDONE] =
                                    r_next.status[`ISF_ST_FDONE] |
                                    r_next.status[`ISF_ST_SECOND];
                                r_next.irq_flag = 1'b1;
                                ev[`ISF_IE_RX]  = 1'b1;
                            end else begin
                                r_next.rx_pend = 1'b1;
                            end
                        end else begin
                            hit_rw = byte_in[0];
                            gc_hit = byte_in == 8'h00;
                            m1_hit = !gc_hit && byte_in[7:1] == r_reg.sar1;
                            // an equal second address never wins over the first
                            m2_hit = !gc_hit && !m1_hit &&
                                     byte_in[7:1] == r_reg.sar2;
                            if (m1_hit || m2_hit || gc_hit) begin
                                r_next.rx_hold  = byte_in;
                                r_next.rx_full  = 1'b1;
                                r_next.transmit_select      = hit_rw & ~gc_hit;
                                r_next.irq_flag = 1'b1;
                                ev[`ISF_IE_RX]  = 1'b1;
                                ev[`ISF_IE_ADDR] = 1'b1;
                            end else begin
                                r_next.st = isf_pkg::isf_ignore;
                            end
                            if (m1_hit || gc_hit) begin
                                r_next.status[`ISF_ST_OWN] = 1'b1;
                            end
                            if (gc_hit) begin
                                r_next.status[`ISF_ST_BCAST] = 1'b1;
                            end
                            if (m2_hit) begin
                                r_next.status[`ISF_ST_FDONE]  = 1'b1;
                                r_next.status[`ISF_ST_SECOND] = 1'b1;
                            end
                        end
                    end
                end
                isf_pkg::isf_aack: begin
                    if (fall_p && r_reg.bitcnt == 4'h0) begin
                        r_next.sda_oe_n = 1'b0;
                        r_next.bitcnt   = 4'h1;
                    end else if (fall_p) begin
                        r_next.sda_oe_n = 1'b1;
                        r_next.bitcnt   = 4'h0;
                        if (r_reg.transmit_select) begin
                            tx_load = 1'b1;
                        end else begin
                            r_next.st = isf_pkg::isf_rx;
                        end
                    end
                end
                isf_pkg::isf_tx: begin
                    if (rise_p) begin
                        r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    end else if (fall_p && r_reg.bitcnt == 4'h8) begin
                        r_next.sda_oe_n = 1'b1;
                        r_next.st       = isf_pkg::isf_tack;
                    end else if (fall_p) begin
                        r_next.shift    = {r_reg.shift[6:0], 1'b1};
                        r_next.sda_oe_n = r_reg.shift[6];
                    end
                end
                isf_pkg::isf_tack: begin
                    if (rise_p) begin
                        r_next.status[`ISF_ST_ACK] = sda_s;
                        r_next.bitcnt              = 4'h9;
                        if (sda_s) begin
                            r_next.st = isf_pkg::isf_ignore;
                        end
                    end else if (fall_p && r_reg.bitcnt == 4'h9) begin
                        tx_load = 1'b1;
                    end
                end
                isf_pkg::isf_idle, isf_pkg::isf_ignore: ;
            endcase
        end

        // transmission end: next byte goes from holding register to shifter
        if (tx_load) begin
            r_next.st     = isf_pkg::isf_tx;
            r_next.bitcnt = 4'h0;
            if (!r_next.tx_empty) begin
                r_next.shift    = r_next.tx_hold;
                r_next.tx_empty = 1'b1;
                r_next.status[`ISF_ST_FDONE] =
                    r_next.status[`ISF_ST_FDONE] |
                    r_next.status[`ISF_ST_SECOND];
                r_next.irq_flag = 1'b1;
                ev[`ISF_IE_TX]  = 1'b1;
            end else begin
                // no clock stretching: an empty buffer sends all ones
                r_next.tx_pend = 1'b1;
                r_next.shift   = 8'hff;
            end
            r_next.sda_oe_n = r_next.shift[7];
        end

        r_next.ist     = (r_reg.ist & ~iclr) | ev;
        r_next.irq     = |(r_next.ist & r_next.imask);
        r_next.sda_out = 1'b0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r_reg          <= '0;
            r_reg.st       <= isf_pkg::isf_idle;
            r_reg.status   <= `ISF_RST_STATUS;
            r_reg.sar1     <= `ISF_RST_SAR;
            r_reg.sar2     <= `ISF_RST_SAR;
            r_reg.imask    <= `ISF_RST_IMASK;
            r_reg.sda_oe_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata   = r_reg.prdata;
    assign pready   = r_reg.pready;
    assign pslverr  = r_reg.pslverr;
    assign irq      = r_reg.irq;
    assign sda_out  = r_reg.sda_out;
    assign sda_oe_n = r_reg.sda_oe_n;

    start_clr_second_a: assert property (@(posedge clock) disable iff (rst)
        start_p |=> !r_reg.status[`ISF_ST_SECOND])
        else $error("second match flag survived a start");
    own_match_a: assert property (@(posedge clock) disable iff (rst)
        m1_hit |=> r_reg.status[`ISF_ST_OWN] && r_reg.rx_full && !r_reg.master_select)
        else $error("own address match flags wrong");
    trs_follows_rw_a: assert property (@(posedge clock) disable iff (rst)
        m1_hit |=> r_reg.transmit_select == $past(hit_rw))
        else $error("transmit select does not follow rw bit");
    second_match_a: assert property (@(posedge clock) disable iff (rst)
        m2_hit |=> r_reg.status[`ISF_ST_FDONE] &&
                   r_reg.status[`ISF_ST_SECOND] && !r_reg.status[`ISF_ST_OWN])
        else $error("second address match flags wrong");
    fdone_gated_a: assert property (@(posedge clock) disable iff (rst)
        $rose(r_reg.status[`ISF_ST_FDONE]) |-> r_reg.status[`ISF_ST_SECOND])
        else $error("frame done set without second match");
    data_wr_clr_a: assert property (@(posedge clock) disable iff (rst)
        data_wr && !r_reg.tx_pend && !tx_load && !start_p |=>
            !r_reg.tx_empty && !r_reg.status[`ISF_ST_OWN])
        else $error("data write did not clear flags");
    rx_full_set_a: assert property (@(posedge clock) disable iff (rst)
        rx_done && !r_reg.rx_full && !data_rd |=> r_reg.rx_full ##1 1'b1)
        else $error("reception end did not set rx full");
    data_rd_clr_a: assert property (@(posedge clock) disable iff (rst)
        data_rd && !r_reg.rx_pend && !rx_done && !m1_hit && !m2_hit &&
        !gc_hit |=> !r_reg.rx_full && !r_reg.status[`ISF_ST_BCAST])
        else $error("data read did not clear flags");
    stop_one_end_a: assert property (@(posedge clock) disable iff (rst)
        stop_p && !r_reg.master_select |=> (r_reg.status[`ISF_ST_ERR] !=
            r_reg.status[`ISF_ST_NORM]) && !r_reg.busy && !r_reg.tx_empty)
        else $error("stop did not set exactly one end flag");
    err_mid_frame_a: assert property (@(posedge clock) disable iff (rst)
        stop_p && !r_reg.master_select && in_frame |=> r_reg.status[`ISF_ST_ERR])
        else $error("stop inside frame not flagged as error");
    irq_clr_err_a: assert property (@(posedge clock) disable iff (rst)
        ctrl_wr && !pwdata[`ISF_CT_IRQ] && !stop_p |=>
            !r_reg.status[`ISF_ST_ERR])
        else $error("error end survived bus irq clear");
    mst_steady_a: assert property (@(posedge clock) disable iff (rst)
        !ctrl_wr |=> $stable(r_reg.master_select))
        else $error("master select changed without software");
endmodule : isf_slave

// ---- testbench/isf_bus_master.sv ----
// remote two-wire master: drives scl and an open-drain sda
// assumes: sda pulled up, four system clocks per bus half period
module isf_bus_master (
    input  wire logic clock,
    input  wire logic sda,
    output logic      scl = 1'b1,
    output logic      sda_drv = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    // sda moves only while scl is low, so no false start or stop
    task automatic bit_out(input logic v);
        @(posedge clock);
        sda_drv <= v;
        repeat (3) @(posedge clock);
        scl <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : bit_out
    task automatic start();
        bit_out(1'b1);
        sda_drv <= 1'b0;
        repeat (4) @(posedge clock);
        scl <= 1'b0;
    endtask : start
    // n bits msb first; a whole byte also clocks the released ack
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            bit_out(b[i]);
            scl <= 1'b0;
        end
        if (n == 8) begin
            bit_out(1'b1);
            scl <= 1'b0;
        end
    endtask : send
    // clocks one byte out of the slave msb first, then acks it low
    task automatic read_ack(output logic [7:0] got);
        got = 8'h00;
        repeat (8) begin
            bit_out(1'b1);
            got = {got[6:0], sda};
            scl <= 1'b0;
        end
        bit_out(1'b0);
        scl <= 1'b0;
    endtask : read_ack
    task automatic stop();
        bit_out(1'b0);
        sda_drv <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : stop
endmodule : isf_bus_master

// ---- testbench/tb_isf_slave.sv ----
// bench for the slave flag block over apb and the two-wire bus
// assumes: the design files and the master model compile first
`include "isf_defs.svh"
module tb_isf_slave;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, scl, sda_drv, sda_out, sda_oe_n;
    logic        err_seen;
    int          fail_count = 0;
    int          tests_run = 0;
    wire logic   sda = sda_drv & (sda_oe_n | sda_out);
    isf_slave isf_slave_i (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
    isf_bus_master m (.clock(clock), .sda(sda), .scl(scl),
        .sda_drv(sda_drv));
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic stop_test();
        $display("compared %0d, mismatched %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: no pready", $time);
            stop_test();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask : rd
    task automatic t_first();
        rd(8'h20, 32'hff, 32'h0);
        chk({31'h0, err_seen}, 32'h1);
        wr(`ISF_OFF_SAR1, 32'ha0);
        wr(`ISF_OFF_IMASK, 32'h4);
        m.start();
        m.send(8'ha0, 8);
        rd(`ISF_OFF_STATUS, 32'hff, 32'h04);
        rd(`ISF_OFF_CTRL, 32'he, 32'h2);
        rd(`ISF_OFF_BUF, 32'h3, 32'h3);
        chk({31'h0, irq}, 32'h0);
        m.send(8'h55, 8);
        rd(`ISF_OFF_DATA, 32'hff, 32'ha0);
        rd(`ISF_OFF_STATUS, 32'hff, 32'h0);
        rd(`ISF_OFF_BUF, 32'h1, 32'h1);
        rd(`ISF_OFF_DATA, 32'hff, 32'h55);
        m.send(8'h3c, 8);
        rd(`ISF_OFF_BUF, 32'h1, 32'h1);
        rd(`ISF_OFF_DATA, 32'hff, 32'h3c);
        m.send(8'h55, 3);
        m.stop();
        rd(`ISF_OFF_STATUS, 32'hff, 32'h80);
        rd(`ISF_OFF_BUF, 32'h3, 32'h0);
        chk({31'h0, irq}, 32'h1);
        wr(`ISF_OFF_IST, 32'hf);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        wr(`ISF_OFF_STATUS, 32'hff);
        rd(`ISF_OFF_STATUS, 32'hff, 32'h80);
        wr(`ISF_OFF_STATUS, 32'h0);
        rd(`ISF_OFF_STATUS, 32'hff, 32'h0);
        $display("test first_address done");
    endtask : t_first
    task automatic t_second();
        wr(`ISF_OFF_SAR2, 32'hb0);
        m.start();
        m.send(8'hb0, 8);
        rd(`ISF_OFF_STATUS, 32'hff, 32'h30);
        rd(`ISF_OFF_BUF, 32'h1, 32'h1);
        m.start();
        rd(`ISF_OFF_STATUS, 32'h10, 32'h0);
        m.stop();
        rd(`ISF_OFF_STATUS, 32'hc0, 32'h40);
        m.start();
        m.send(8'h55, 3);
        m.stop();
        rd(`ISF_OFF_STATUS, 32'hc0, 32'h80);
        wr(`ISF_OFF_CTRL, 32'h0);
        rd(`ISF_OFF_STATUS, 32'ha0, 32'h0);
        $display("test second_address done");
    endtask : t_second
    task automatic t_transmit();
        logic [7:0] rb;
        m.start();
        wr(`ISF_OFF_DATA, 32'h3c);
        rd(`ISF_OFF_BUF, 32'h2, 32'h0);
        m.send(8'ha1, 8);
        rd(`ISF_OFF_CTRL, 32'h8, 32'h8);
        m.read_ack(rb);
        chk({24'h0, rb}, 32'h3c);
        rd(`ISF_OFF_BUF, 32'h2, 32'h2);
        wr(`ISF_OFF_DATA, 32'h5a);
        rd(`ISF_OFF_BUF, 32'h2, 32'h2);
        rd(`ISF_OFF_STATUS, 32'hff, 32'h0);
        m.send(8'hff, 8);
        m.stop();
        rd(`ISF_OFF_STATUS, 32'hc1, 32'h41);
        rd(`ISF_OFF_BUF, 32'h2, 32'h0);
        $display("test transmit done");
    endtask : t_transmit
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_first();
        t_second();
        t_transmit();
        stop_test();
    end
endmodule : tb_isf_slave
